// file: slw_port.v
// synchronous late-write pipelined sram port with its own core array
// assumes all sync inputs are timed to clock; sleep and output enable may be async
`timescale 1ns/1ps
`include "slw_map.vh"
module slw_port #(
    parameter ADDR_W = `SLW_ADDR_W,
    parameter LANES  = `SLW_LANES,
    parameter LANE_W = `SLW_LANE_W
) (
    input  wire                    clock,
    input  wire                    rst_n,
    input  wire [ADDR_W-1:0]       address,
    input  wire                    clockGateN,
    input  wire                    chipSelectFirstN,
    input  wire                    chipSelectSecond,
    input  wire                    chipSelectThirdN,
    input  wire                    writeEnableN,
    input  wire [LANES-1:0]        laneWriteN,
    input  wire                    loadAdvance,
    input  wire                    outputEnableN,
    input  wire                    sleepRequest,
    input  wire                    pipelineModeSelectN,
    input  wire                    burstOrderSelectN,
    input  wire                    paritySelectN,
    input  wire [LANES*LANE_W-1:0] dataIn,
    output reg  [LANES*LANE_W-1:0] dataOut,
    output reg                     dataOe
);
    localparam W = LANES * LANE_W;

    // ************************************************************
    // input synchronisers for asynchronous pins
    // ************************************************************
    reg sleepMeta_r;
    reg sleep_r;
    reg oeMeta_r;
    reg oeN_r;
    reg lboMeta_r;
    reg lbo_r;
    reg ftMeta_r;
    reg ft_r;
    reg peMeta_r;
    reg pe_r;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleepMeta_r <= 1'b0;
            sleep_r     <= 1'b0;
            oeMeta_r    <= 1'b1;
            oeN_r       <= 1'b1;
            lboMeta_r   <= 1'b0;
            lbo_r       <= 1'b0;
            ftMeta_r    <= 1'b1;
            ft_r        <= 1'b1;
            peMeta_r    <= 1'b0;
            pe_r        <= 1'b0;
        end else begin
            sleepMeta_r <= sleepRequest;
            sleep_r     <= sleepMeta_r;
            oeMeta_r    <= outputEnableN;
            oeN_r       <= oeMeta_r;
            lboMeta_r   <= burstOrderSelectN;
            lbo_r       <= lboMeta_r;
            ftMeta_r    <= pipelineModeSelectN;
            ft_r        <= ftMeta_r;
            peMeta_r    <= paritySelectN;
            pe_r        <= peMeta_r;
        end
    end

    // ************************************************************
    // command decode
    // ************************************************************
    // ungated edge outside sleep
    wire edgeOk   = !clockGateN && !sleep_r;
    wire selected = !chipSelectFirstN && chipSelectSecond && !chipSelectThirdN;
    wire loadCmd  = edgeOk && !loadAdvance;
    wire advCmd   = edgeOk && loadAdvance;
    wire newRead  = loadCmd && selected && writeEnableN;
    wire newWrite = loadCmd && selected && !writeEnableN;

    reg  [1:0]        lastCmd_r;
    reg  [ADDR_W-1:0] addr_r;
    wire [1:0]        burstAddr;

    // preset counter from low address bits
    slw_burst_addr u_burst (
        .clock             (clock),
        .rst_n             (rst_n),
        .load              (newRead || newWrite),
        .advance           (advCmd && lastCmd_r != `SLW_CMD_IDLE),
        .preset            (address[`SLW_BURST_W-1:0]),
        .burstOrderSelectN (lbo_r),
        .burstAddr         (burstAddr)
    );

    // continue cycles reuse the previous command type
    wire contRead  = advCmd && lastCmd_r == `SLW_CMD_READ;
    wire contWrite = advCmd && lastCmd_r == `SLW_CMD_WRITE;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lastCmd_r <= `SLW_CMD_IDLE;
            addr_r    <= {ADDR_W{1'b0}};
        end else if (loadCmd) begin
            lastCmd_r <= newRead ? `SLW_CMD_READ : (newWrite ? `SLW_CMD_WRITE : `SLW_CMD_IDLE);
            addr_r    <= address;
        end
    end

    wire [ADDR_W-1:0] curAddr = loadCmd ? address : {addr_r[ADDR_W-1:`SLW_BURST_W], burstAddr};

    // ************************************************************
    // read and write pipelines
    // ************************************************************
    reg              rdV1_r;
    reg              rdV2_r;
    reg              wrV1_r;
    reg              wrV2_r;
    reg [ADDR_W-1:0] rdA1_r;
    reg [ADDR_W-1:0] wrA1_r;
    reg [ADDR_W-1:0] wrA2_r;
    reg [LANES-1:0]  wrL1_r;
    reg [LANES-1:0]  wrL2_r;

    wire rdNow = newRead || contRead;
    // lanes ignored on reads, all-high is a no-op
    wire wrNow = (newWrite || contWrite) && (laneWriteN != `SLW_LANES_OFF);

    wire flow = !ft_r;
    // pipelined write data two edges later
    // flow-through write data one edge later
    wire             wrDue  = flow ? wrV1_r : wrV2_r;
    wire [ADDR_W-1:0] wrAddr = flow ? wrA1_r : wrA2_r;
    wire [LANES-1:0] wrLane = flow ? wrL1_r : wrL2_r;

    function [W-1:0] parityMask;
        input pe;
        integer k;
        begin
            parityMask = {W{1'b1}};
            for (k = 0; k < LANES; k = k + 1)
                parityMask[k*LANE_W+LANE_W-1] = !pe;
        end
    endfunction

    wire [W-1:0] pMask = parityMask(pe_r);

    // nothing moves on a gated edge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdV1_r <= 1'b0;
            rdV2_r <= 1'b0;
            wrV1_r <= 1'b0;
            wrV2_r <= 1'b0;
            rdA1_r <= {ADDR_W{1'b0}};
            wrA1_r <= {ADDR_W{1'b0}};
            wrA2_r <= {ADDR_W{1'b0}};
            wrL1_r <= `SLW_LANES_OFF;
            wrL2_r <= `SLW_LANES_OFF;
        end else if (!clockGateN) begin
            rdV1_r <= rdNow;
            rdA1_r <= curAddr;
            rdV2_r <= rdV1_r;
            wrV1_r <= wrNow;
            wrA1_r <= curAddr;
            wrL1_r <= laneWriteN;
            wrV2_r <= wrV1_r;
            wrA2_r <= wrA1_r;
            wrL2_r <= wrL1_r;
        end
    end

    // ************************************************************
    // core array, one memory per byte lane
    // ************************************************************
    // a separate array per lane keeps each memory to a single writing process
    wire [ADDR_W-1:0] rdAddr = flow ? curAddr : rdA1_r;
    wire [W-1:0]      coreRaw;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : gLane
            reg [LANE_W-1:0] laneMem [0:(1<<ADDR_W)-1];
            always @(posedge clock) begin
                if (!clockGateN && wrDue && !wrLane[g])
                    laneMem[wrAddr] <= dataIn[g*LANE_W +: LANE_W] & pMask[g*LANE_W +: LANE_W];
            end
            assign coreRaw[g*LANE_W +: LANE_W] = laneMem[rdAddr];
        end
    endgenerate

    // ************************************************************
    // output register and drivers
    // ************************************************************
    // parity bits masked in narrow mode
    wire [W-1:0] coreRead = coreRaw & pMask;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= {W{1'b0}};
            dataOe  <= 1'b0;
        end else begin
            if (!clockGateN) begin
                // pipelined output one edge after access
                // flow-through data right after address edge
                if (flow ? rdNow : rdV1_r)
                    dataOut <= coreRead;
            end
            // drivers off unless a read is presented
            // a frozen pipelined read keeps driving the bus
            if (oeN_r || sleep_r)
                dataOe <= 1'b0;
            else if (!clockGateN)
                dataOe <= flow ? rdNow : rdV1_r;
        end
    end
endmodule // slw_port

// file: slw_map.vh
// constants for the synchronous late-write sram port
// assumes it is included by the port logic only
`ifndef SLW_MAP_VH
`define SLW_MAP_VH
`define SLW_LANES      4
`define SLW_LANE_W     9
`define SLW_ADDR_W     18
`define SLW_BURST_W    2
`define SLW_BURST_LAST 2'h3
`define SLW_BURST_ZERO 2'h0
`define SLW_BURST_STEP 2'h1
`define SLW_LANES_OFF  4'hf
`define SLW_CMD_IDLE   2'h0
`define SLW_CMD_READ   2'h1
`define SLW_CMD_WRITE  2'h2
`endif

// file: slw_burst_addr.v
// burst address counter: loads a preset, then steps linear or interleaved
// assumes the caller supplies load and advance as one-cycle qualified strobes
`timescale 1ns/1ps
`include "slw_map.vh"
module slw_burst_addr (
    input  wire                      clock,
    input  wire                      rst_n,
    input  wire                      load,
    input  wire                      advance,
    input  wire [`SLW_BURST_W-1:0]   preset,
    input  wire                      burstOrderSelectN,
    output wire [`SLW_BURST_W-1:0]   burstAddr
);
    reg [`SLW_BURST_W-1:0] base_r;
    reg [`SLW_BURST_W-1:0] count_r;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            base_r  <= `SLW_BURST_ZERO;
            count_r <= `SLW_BURST_ZERO;
        end else if (load) begin
            base_r  <= preset;
            // the load cycle itself uses the pin address, so the count starts one step ahead
            count_r <= `SLW_BURST_STEP;
        end else if (advance) begin
            count_r <= count_r + `SLW_BURST_STEP;
        end
    end

    assign burstAddr = burstOrderSelectN ? (base_r ^ count_r) : (base_r + count_r);
endmodule // slw_burst_addr

// file: slw_port_asserts.sv
// output checks for the late-write sram port
// bound onto slw_port; sees its ports only
`timescale 1ns/1ps
module slw_port_asserts #(parameter LANES = 4, parameter LANE_W = 9) (
    input wire                    clock,
    input wire                    rst_n,
    input wire                    clockGateN,
    input wire                    chipSelectFirstN,
    input wire                    chipSelectSecond,
    input wire                    chipSelectThirdN,
    input wire                    writeEnableN,
    input wire                    loadAdvance,
    input wire                    outputEnableN,
    input wire                    sleepRequest,
    input wire                    pipelineModeSelectN,
    input wire                    paritySelectN,
    input wire [LANES*LANE_W-1:0] dataOut,
    input wire                    dataOe
);
    reg  [2:0] calm;
    reg  [2:0] mode;
    wire       sel  = !chipSelectFirstN && chipSelectSecond && !chipSelectThirdN;
    wire       go   = !clockGateN && !loadAdvance && sel && !sleepRequest;
    wire       tick = !clockGateN && &calm;
    wire       pip  = &mode && pipelineModeSelectN;
    wire       flo  = ~|mode && !pipelineModeSelectN;
    // async pins pass two flops, so only settled history counts
    always @(posedge clock) begin
        calm <= {calm[1:0], !sleepRequest && !outputEnableN};
        mode <= {mode[1:0], pipelineModeSelectN};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rdPipe; tick && go && writeEnableN && pip ##1 tick |=> dataOe; endproperty
    a_rdPipe: assert property (p_rdPipe) else $error("pipelined read data not driven");
    property p_rdFlow; tick && go && writeEnableN && flo |=> dataOe; endproperty
    a_rdFlow: assert property (p_rdFlow) else $error("flow-through read data not driven");
    property p_wrOff; tick && go && !writeEnableN && pip ##1 tick |=> !dataOe; endproperty
    a_wrOff: assert property (p_wrOff) else $error("drivers on in write data cycle");
    property p_freeze; clockGateN && &calm |=> $stable(dataOut) && $stable(dataOe); endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved on gated edge");
    property p_sleepOff; sleepRequest [*3] |=> !dataOe; endproperty
    a_sleepOff: assert property (p_sleepOff) else $error("drivers on in sleep");
    property p_oeOff; outputEnableN [*3] |=> !dataOe; endproperty
    a_oeOff: assert property (p_oeOff) else $error("drivers on with output enable high");
    property p_desel; (!clockGateN && !loadAdvance && !sel) [*2] |=> !dataOe; endproperty
    a_desel: assert property (p_desel) else $error("drivers on while deselected");
    property p_parity;
        $rose(dataOe) && paritySelectN && $past(paritySelectN, 3)
        |-> !{dataOut[4*LANE_W-1], dataOut[3*LANE_W-1], dataOut[2*LANE_W-1], dataOut[LANE_W-1]};
    endproperty
    a_parity: assert property (p_parity) else $error("parity bits not masked");
endmodule // slw_port_asserts
bind slw_port slw_port_asserts #(.LANES(LANES), .LANE_W(LANE_W)) slw_port_asserts_inst (
    .clock, .rst_n, .clockGateN, .chipSelectFirstN, .chipSelectSecond, .chipSelectThirdN, .writeEnableN,
    .loadAdvance, .outputEnableN, .sleepRequest, .pipelineModeSelectN, .paritySelectN, .dataOut, .dataOe);

// file: slw_host_model.sv
// write-data side of the host memory controller
// assumes the bench flags each write command in the cycle it is presented
`timescale 1ns/1ps
module slw_host_model (
    input wire        clock,
    input wire        clockGateN,
    input wire        flowMode,
    input wire        wrCmd,
    input wire [35:0] wrData,
    output reg [35:0] dataIn
);
    reg [35:0] stage_r = 36'h0;
    reg        due_r = 1'b0;
    initial dataIn = 36'h0;
    // data two or one ungated edges late
    always @(posedge clock) begin
        if (!clockGateN) begin
            stage_r <= wrData;
            due_r <= wrCmd;
            // an idle bus shows the inverse of its last value, never a stale copy
            dataIn <= #1 (flowMode && wrCmd) ? wrData : (!flowMode && due_r) ? stage_r : ~dataIn;
        end
    end
endmodule // slw_host_model

// file: tb_top.sv
// self-checking bench for the late-write sram port
// assumes the port, host model and checker are compiled first
`timescale 1ns/1ps
module tb_top;
    localparam PMASK = 36'h804020100;
    reg         clock = 1'b0;
    reg         rst_n = 1'b0;
    reg  [17:0] address = 18'h0;
    reg         gateN = 1'b0;
    reg  [2:0]  cs = 3'b110;
    reg         weN = 1'b1;
    reg  [3:0]  laneN = 4'h0;
    reg         load_advance = 1'b0;
    reg         oeN = 1'b0;
    reg         sleep = 1'b0;
    reg         pipeN = 1'b1;
    reg         burstN = 1'b0;
    reg         parityN = 1'b0;
    reg         wrCmd = 1'b0;
    reg  [35:0] wrData = 36'h0;
    wire [35:0] dataIn;
    wire [35:0] dataOut;
    wire        dataOe;
    reg  [35:0] shadow [0:15];
    integer     fail_count = 0;
    integer     compares = 0;
    integer     i;
    integer     j;
    always #2.5 clock = ~clock;
    slw_port slw_port_inst (.clock(clock), .rst_n(rst_n), .address(address), .clockGateN(gateN),
        .chipSelectFirstN(cs[2]), .chipSelectSecond(cs[1]), .chipSelectThirdN(cs[0]), .writeEnableN(weN),
        .laneWriteN(laneN), .loadAdvance(load_advance), .outputEnableN(oeN), .sleepRequest(sleep),
        .pipelineModeSelectN(pipeN), .burstOrderSelectN(burstN), .paritySelectN(parityN),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
    slw_host_model slw_host_model_inst (.clock(clock), .clockGateN(gateN), .flowMode(!pipeN),
        .wrCmd(wrCmd), .wrData(wrData), .dataIn(dataIn));
    task tick(input integer n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk36(input [35:0] exp, input [35:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch dataOut expected %h seen %h", exp, got);
        end
    endtask
    task chk1(input exp, input got);
        compares = compares + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch dataOe expected %b seen %b", exp, got);
        end
    endtask
    task idle(input integer n);
        cs = 3'b110;
        load_advance = 1'b0;
        weN = 1'b1;
        wrCmd = 1'b0;
        tick(n);
    endtask
    // continue cycles scramble the address: the counter must supply it
    task cmd(input [2:0] s, input w, input a, input [17:0] ad, input [3:0] ln, input [35:0] d);
        cs = s;
        weN = !w;
        load_advance = a;
        address = a ? ~ad : ad;
        laneN = ln;
        wrCmd = w;
        wrData = d;
        tick(1);
    endtask
    task wr(input a, input [17:0] ad, input [3:0] ln, input [35:0] d);
        cmd(3'b010, 1'b1, a, ad, ln, d);
        for (i = 0; i < 4; i = i + 1)
            if (!ln[i]) shadow[ad[3:0]][9*i +: 9] = d[9*i +: 9];
    endtask
    // lanes held low on reads to show they are ignored
    task rd(input [17:0] ad, input integer lat);
        cmd(3'b010, 1'b0, 1'b0, ad, 4'h0, 36'h0);
        // the output stands for one cycle, from the edge before the host takes it
        idle(lat - 1);
        chk36(parityN ? shadow[ad[3:0]] & ~PMASK : shadow[ad[3:0]], dataOut);
        chk1(1'b1, dataOe);
    endtask
    task results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        tick(10);
        rst_n = 1'b1;
        idle(3);
        wr(0, 18'h4, 4'h0, 36'h123456789);
        wr(0, 18'h5, 4'h0, 36'hfedcba987);
        idle(2);
        rd(4, 2);
        rd(5, 2);
        for (j = 0; j < 5; j = j + 1) begin
            wr(0, 18'h4, (j < 4) ? ~(4'h1 << j) : 4'hf, 36'h5a5a5a5a5 ^ j);
            idle(2);
            rd(4, 2);
        end
        for (j = 0; j < 5; j = j + 1) wr(j != 0, 18'h8 | ((1 + j) & 3), 4'h0, 36'h100 + j);
        idle(2);
        for (j = 8; j < 12; j = j + 1) rd(j, 2);
        burstN = 1'b1;
        idle(3);
        for (j = 0; j < 4; j = j + 1) wr(j != 0, 18'hc | (1 ^ j), 4'h0, 36'h200 + j);
        idle(2);
        for (j = 12; j < 16; j = j + 1) rd(j, 2);
        for (j = 0; j < 3; j = j + 1) cmd(3'b010 ^ (3'b100 >> j), 1'b1, 1'b0, 18'h4, 4'h0, 36'hbad);
        idle(3);
        rd(4, 2);
        sleep = 1'b1;
        idle(3);
        cmd(3'b010, 1'b1, 1'b0, 18'h4, 4'h0, 36'h0);
        idle(1);
        sleep = 1'b0;
        idle(4);
        rd(4, 2);
        wr(0, 18'h6, 4'h0, 36'h777777777);
        gateN = 1'b1;
        idle(4);
        gateN = 1'b0;
        idle(3);
        rd(6, 2);
        parityN = 1'b1;
        idle(3);
        rd(5, 2);
        parityN = 1'b0;
        oeN = 1'b1;
        idle(3);
        cmd(3'b010, 1'b0, 1'b0, 18'h5, 4'h0, 36'h0);
        idle(2);
        chk1(1'b0, dataOe);
        oeN = 1'b0;
        pipeN = 1'b0;
        idle(3);
        wr(0, 18'h7, 4'h0, 36'h3c3c3c3c3);
        idle(2);
        rd(7, 1);
        results;
    end
endmodule // tb_top
